/* File: input_capture_channel.sv */
// Summary of operation
// - Event copies selected 16-bit timer count
// - Timebase bit one first timer, zero second
// - Mode 000 turns channel off
// - Mode 001 captures every edge
// - Every-edge mode ignores captures per interrupt
// - 010 falling edges, 011 rising edges
// - 100 every fourth, 101 every sixteenth rise
// - Mode 110 unused, acts disabled
// - Mode 111 rising-edge wake source only
// - Interrupt after one to four captures
// - Captures kept in four-deep buffer
// - Not-empty flag shows unread values
// - Overflow flag set on capture overflow
// - Idle halt bit stops channel in idle, except in mode 111
// - Pin event wakes sleep and idle
//
// Purpose: One input capture channel with buffer, interrupt and wake
// Assumes: Pin and timer counts synchronous to clk_in
// Notes: Overflow clears in hardware once the buffer drains empty
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "capture_regs.svh"
module input_capture_channel (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic capture_input_pin_in,
    input wire logic [15:0] first_shared_timer_count_in,
    input wire logic [15:0] second_shared_timer_count_in,
    input wire logic cpu_idle_in,
    input wire logic cpu_sleep_in,
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    output logic irq_out,
    output logic wake_out
);
    logic [15:0] ctl_r;
    logic [15:0] ctl_nxt;
    logic [1:0] cap_cnt_r;
    logic [1:0] cap_cnt_nxt;
    logic ovf_r;
    logic ovf_nxt;
    logic [`IRQ_BITS-1:0] sts_r;
    logic [`IRQ_BITS-1:0] sts_nxt;
    logic [`IRQ_BITS-1:0] mask_r;
    logic [`IRQ_BITS-1:0] mask_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic wake_r;
    logic wake_nxt;
    logic [15:0] stamp;
    logic [2:0] mode;
    logic run;
    logic cap_event;
    logic pin_wake;
    logic drop;
    logic pop;
    logic cap_irq;
    logic [15:0] head;
    logic [2:0] level;

    // Halted in idle with halt selected, unless in wake mode
    assign mode = ctl_r[`CTL_MODE_HI:`CTL_MODE_LO];
    assign run = !(cpu_idle_in && ctl_r[`CTL_IDLE_HALT])
                 || (mode == capture_pkg::MODE_WAKE);
    // Timebase choice
    assign stamp = ctl_r[`CTL_TIMEBASE] ? first_shared_timer_count_in
                                        : second_shared_timer_count_in;
    assign pop = rd_in && (addr_in == `ADDR_BUFFER);

    capture_edge_detect u_capture_edge_detect (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pin_in(capture_input_pin_in),
        .run_in(run),
        .mode_in(mode),
        .event_out(cap_event),
        .wake_out(pin_wake)
    );

    capture_fifo u_capture_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .push_in(cap_event),
        .data_in(stamp),
        .pop_in(pop),
        .head_out(head),
        .count_out(level),
        .drop_out(drop)
    );

    // Captures per interrupt, overflow and control writes
    always_comb begin
        ctl_nxt = ctl_r;
        cap_cnt_nxt = cap_cnt_r;
        cap_irq = 1'b0;
        ovf_nxt = ovf_r;
        if (wr_in && addr_in == `ADDR_CONTROL) begin
            ctl_nxt = wdata_in & `CTL_WR_MASK;
            cap_cnt_nxt = 2'h0; // Restart count on reprogramming
        end else if (cap_event) begin
            if (mode == capture_pkg::MODE_BOTH) begin
                cap_irq = 1'b1;
            end else if (cap_cnt_r == ctl_r[`CTL_CPI_HI:`CTL_CPI_LO]) begin
                cap_irq = 1'b1;
                cap_cnt_nxt = 2'h0;
            end else begin
                cap_cnt_nxt = cap_cnt_r + 2'h1;
            end
        end
        // Set wins over the drain-clear
        if (drop) begin
            ovf_nxt = 1'b1;
        end else if (level == 3'h0) begin
            ovf_nxt = 1'b0;
        end
    end

    // Sticky status, write one to clear; a new event wins
    always_comb begin
        mask_nxt = mask_r;
        sts_nxt = sts_r;
        if (wr_in && addr_in == `ADDR_IRQ_STATUS) begin
            sts_nxt = sts_r & ~wdata_in[`IRQ_BITS-1:0];
        end
        if (wr_in && addr_in == `ADDR_IRQ_MASK) begin
            mask_nxt = wdata_in[`IRQ_BITS-1:0];
        end
        if (cap_irq) begin
            sts_nxt[`IRQ_CAPTURE] = 1'b1;
        end
        if (drop) begin
            sts_nxt[`IRQ_OVERFLOW] = 1'b1;
        end
        if (pin_wake && (cpu_idle_in || cpu_sleep_in)) begin
            sts_nxt[`IRQ_WAKE] = 1'b1;
        end
        // Wake on any qualifying pin activity while asleep or idle
        wake_nxt = (cpu_idle_in || cpu_sleep_in) && (cap_event || pin_wake);
    end

    // Read mux, data one cycle after the strobe
    always_comb begin
        rdata_nxt = 16'h0000;
        if (rd_in) begin
            case (addr_in)
                `ADDR_CONTROL: begin
                    rdata_nxt = ctl_r;
                    rdata_nxt[`CTL_OVF] = ovf_r;
                    rdata_nxt[`CTL_BNE] = (level != 3'h0);
                end
                `ADDR_BUFFER: rdata_nxt = head;
                `ADDR_IRQ_STATUS: rdata_nxt = {13'h0000, sts_r};
                `ADDR_IRQ_MASK: rdata_nxt = {13'h0000, mask_r};
                `ADDR_POWER: rdata_nxt = {14'h0000, cpu_sleep_in, cpu_idle_in};
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    // All registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctl_r <= `CTL_RESET;
            cap_cnt_r <= 2'h0;
            ovf_r <= 1'b0;
            sts_r <= '0;
            mask_r <= '0;
            rdata_r <= 16'h0000;
            wake_r <= 1'b0;
        end else begin
            ctl_r <= ctl_nxt;
            cap_cnt_r <= cap_cnt_nxt;
            ovf_r <= ovf_nxt;
            sts_r <= sts_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
            wake_r <= wake_nxt;
        end
    end

    assign rdata_out = rdata_r;
    assign irq_out = |(sts_r & mask_r);
    assign wake_out = wake_r;

    // Checks
    a_off_no_capture: assert property (@(posedge clk_in) disable iff (rst_in)
        (mode == 3'h0 || mode == 3'h6 || mode == 3'h7) |-> !cap_event)
        else $error("capture while disabled");
    a_stamp_stored: assert property (@(posedge clk_in) disable iff (rst_in)
        (cap_event && level == 3'h0 && !pop) |=> (head == $past(stamp)))
        else $error("captured value wrong");
    a_bne_tracks: assert property (@(posedge clk_in) disable iff (rst_in)
        (rd_in && addr_in == `ADDR_CONTROL) |=> (rdata_out[`CTL_BNE] == ($past(level) != 3'h0)))
        else $error("not-empty flag wrong");
    a_full_drop: assert property (@(posedge clk_in) disable iff (rst_in)
        (cap_event && level == 3'h4 && !pop) |=> (ovf_r && level == 3'h4))
        else $error("overflow not flagged");
    a_pop_oldest: assert property (@(posedge clk_in) disable iff (rst_in)
        (pop && level != 3'h0 && !cap_event) |=> (level == $past(level) - 3'h1))
        else $error("read did not remove");
    a_idle_halt: assert property (@(posedge clk_in) disable iff (rst_in)
        (cpu_idle_in && ctl_r[`CTL_IDLE_HALT]) |-> !cap_event)
        else $error("capture during idle halt");
    a_every_edge_irq: assert property (@(posedge clk_in) disable iff (rst_in)
        (cap_event && mode == 3'h1 && !wr_in) |=> sts_r[`IRQ_CAPTURE])
        else $error("every-edge interrupt missing");
    a_wake_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
        (pin_wake && cpu_sleep_in) |=> wake_out)
        else $error("no wake");
    a_irq_level: assert property (@(posedge clk_in) disable iff (rst_in)
        irq_out == |(sts_r & mask_r) ##1 1'b1)
        else $error("interrupt level wrong");
    c_capture: cover property (@(posedge clk_in) cap_event);
    c_overflow: cover property (@(posedge clk_in) drop);
    c_wake: cover property (@(posedge clk_in) wake_out);
    c_irq: cover property (@(posedge clk_in) irq_out);
endmodule
`default_nettype wire

/* File: capture_regs.svh */
// Purpose: Register map, field positions and reset values of the capture channel
// Assumes: Plain register port, one 16-bit word per offset
// Notes: Definitions only
`ifndef CAPTURE_REGS_SVH
`define CAPTURE_REGS_SVH
`define ADDR_CONTROL 4'h0
`define ADDR_BUFFER 4'h1
`define ADDR_IRQ_STATUS 4'h2
`define ADDR_IRQ_MASK 4'h3
`define ADDR_POWER 4'h4
`define CTL_IDLE_HALT 13
`define CTL_TIMEBASE 7
`define CTL_CPI_HI 6
`define CTL_CPI_LO 5
`define CTL_OVF 4
`define CTL_BNE 3
`define CTL_MODE_HI 2
`define CTL_MODE_LO 0
`define CTL_WR_MASK 16'h20e7
`define CTL_RESET 16'h0000
`define IRQ_CAPTURE 0
`define IRQ_OVERFLOW 1
`define IRQ_WAKE 2
`define IRQ_BITS 3
`define PWR_IDLE 0
`define PWR_SLEEP 1
`define PRESCALE_4 4'h3
`define PRESCALE_16 4'hf
`define FIFO_DEPTH 4
`endif

/* File: capture_pkg.sv */
// Purpose: Types shared by the capture channel files
// Assumes: Nothing beyond the register header
// Notes: Mode codes follow the control register field
package capture_pkg;
    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        MODE_BOTH = 3'h1,
        MODE_FALL = 3'h2,
        MODE_RISE = 3'h3,
        MODE_RISE4 = 3'h4,
        MODE_RISE16 = 3'h5,
        MODE_UNUSED = 3'h6,
        MODE_WAKE = 3'h7
    } capture_mode_t;
endpackage

/* File: capture_edge_detect.sv */
// Purpose: Edge detector and rising-edge prescaler for the capture pin
// Assumes: Pin is synchronous to clk_in
// Notes: Prescaler restarts whenever the mode changes
`timescale 1ns/10ps
`default_nettype none
`include "capture_regs.svh"
module capture_edge_detect (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic pin_in,
    input wire logic run_in,
    input wire logic [2:0] mode_in,
    output logic event_out,
    output logic wake_out
);
    logic pin_r;
    logic pin_nxt;
    logic [3:0] pre_r;
    logic [3:0] pre_nxt;
    logic [2:0] mode_r;
    logic [2:0] mode_nxt;
    logic rise;
    logic fall;
    // Edges against previous sample
    always_comb begin
        rise = pin_in && !pin_r;
        fall = !pin_in && pin_r;
        pin_nxt = pin_in;
        mode_nxt = mode_in;
        pre_nxt = pre_r;
        event_out = 1'b0;
        wake_out = 1'b0;
        if (mode_in != mode_r) begin
            pre_nxt = 4'h0; // Fresh count after a mode change
        end else if (run_in) begin
            case (capture_pkg::capture_mode_t'(mode_in))
                capture_pkg::MODE_BOTH: event_out = rise || fall;
                capture_pkg::MODE_FALL: event_out = fall;
                capture_pkg::MODE_RISE: event_out = rise;
                capture_pkg::MODE_RISE4: begin
                    if (rise) begin
                        event_out = (pre_r[1:0] == 2'(`PRESCALE_4));
                        pre_nxt = {2'h0, pre_r[1:0] + 2'h1};
                    end
                end
                capture_pkg::MODE_RISE16: begin
                    if (rise) begin
                        event_out = (pre_r == `PRESCALE_16);
                        pre_nxt = pre_r + 4'h1;
                    end
                end
                capture_pkg::MODE_WAKE: wake_out = rise;
                default: event_out = 1'b0;
            endcase
        end
    end
    // State registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pin_r <= 1'b0;
            pre_r <= 4'h0;
            mode_r <= 3'h0;
        end else begin
            pin_r <= pin_nxt;
            pre_r <= pre_nxt;
            mode_r <= mode_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: capture_fifo.sv */
// Purpose: Four-deep capture buffer, oldest first
// Assumes: Nothing; a pop on an empty buffer is ignored
// Notes: A push into a full buffer is refused and flagged
`timescale 1ns/10ps
`default_nettype none
`include "capture_regs.svh"
module capture_fifo (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic push_in,
    input wire logic [15:0] data_in,
    input wire logic pop_in,
    output logic [15:0] head_out,
    output logic [2:0] count_out,
    output logic drop_out
);
    logic [15:0] mem_r [0:`FIFO_DEPTH-1];
    logic [1:0] rd_r;
    logic [1:0] rd_nxt;
    logic [1:0] wr_r;
    logic [1:0] wr_nxt;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic do_push;
    logic do_pop;
    // Pointer and count update
    always_comb begin
        do_pop = pop_in && (cnt_r != 3'h0);
        do_push = push_in && (cnt_r != 3'(`FIFO_DEPTH));
        drop_out = push_in && (cnt_r == 3'(`FIFO_DEPTH));
        rd_nxt = do_pop ? rd_r + 2'h1 : rd_r;
        wr_nxt = do_push ? wr_r + 2'h1 : wr_r;
        cnt_nxt = cnt_r + {2'h0, do_push} - {2'h0, do_pop};
    end
    // Registers; storage needs no reset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_r <= 2'h0;
            wr_r <= 2'h0;
            cnt_r <= 3'h0;
        end else begin
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            cnt_r <= cnt_nxt;
        end
        if (do_push) begin
            mem_r[wr_r] <= data_in;
        end
    end
    assign head_out = (cnt_r == 3'h0) ? 16'h0000 : mem_r[rd_r];
    assign count_out = cnt_r;
endmodule
`default_nettype wire

/* File: capture_pin_source.sv */
// Purpose: Model of the external signal on the capture pin
// Assumes: The signal is synchronous to clk_in
// Notes: Hold time after each change lets the bench act fast or slow
`timescale 1ns/10ps
`default_nettype none
module capture_pin_source (
    input wire logic clk_in,
    output logic pin_out
);
    // Pin idles low; the source always drives it
    initial begin
        pin_out = 1'b0;
    end

    // One level change just after an edge, then held for hold cycles
    task automatic drive(input logic v, input int hold);
        @(posedge clk_in);
        pin_out <= v;
        repeat (hold) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

/* File: input_capture_channel_bench.sv */
// Purpose: Self-checking bench for the input capture channel
// Assumes: Pin source model drives the capture pin; timers come from the bench
// Notes: Reads note their expected data in a queue; a monitor compares later
`timescale 1ns/10ps
`default_nettype none
`include "capture_regs.svh"
module input_capture_channel_bench;
    logic clk_in, rst_in, pin, idle, sleep, wr, rd, rd_d, irq, wake, ovf;
    logic [15:0] t1, t2, wdata, rdata, ctl;
    logic [3:0] addr;
    logic [2:0] st, mask;
    logic [15:0] notes[$];
    logic [15:0] caps[$];
    int fails, n_checks, seed, pre, cnt, wakes;

    input_capture_channel u_input_capture_channel (.clk_in(clk_in), .rst_in(rst_in),
        .capture_input_pin_in(pin), .first_shared_timer_count_in(t1),
        .second_shared_timer_count_in(t2), .cpu_idle_in(idle), .cpu_sleep_in(sleep),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .irq_out(irq), .wake_out(wake));
    capture_pin_source src (.clk_in(clk_in), .pin_out(pin));

    // 250 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    task automatic print_verdict();
        if (fails == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] act, input logic [15:0] exp);
        n_checks++;
        if (act !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    // One bus cycle; for a read, d is the expected data noted for the monitor
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        if (!w) notes.push_back(d);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk_in);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, so compare there
    always @(posedge clk_in) begin
        if (rd_d) chk(rdata, (notes.size() > 0) ? notes.pop_front() : 16'hdead);
        if (wake === 1'b1) wakes++;
        rd_d <= rd;
    end

    // Writing zero first forces a mode change, which restarts the prescaler; each control write restarts the capture count
    task automatic set_ctl(input logic [15:0] v);
        bus(1'b1, `ADDR_CONTROL, 16'h0000);
        bus(1'b1, `ADDR_CONTROL, v);
        ctl = v;
        pre = 0;
        cnt = 0;
    endtask

    task automatic rd_ctl();
        bus(1'b0, `ADDR_CONTROL, (ctl & `CTL_WR_MASK) | {11'h0, ovf, caps.size() != 0, 3'h0});
    endtask

    // Status read, then the interrupt level against status and mask
    task automatic rd_st();
        bus(1'b0, `ADDR_IRQ_STATUS, {13'h0, st});
        chk({15'h0, irq}, {15'h0, |(st & mask)});
    endtask

    task automatic clr_st(input logic [2:0] v);
        bus(1'b1, `ADDR_IRQ_STATUS, {13'h0, v});
        st = st & ~v;
    endtask

    task automatic set_pwr(input logic i, input logic s);
        idle <= i;
        sleep <= s;
        @(posedge clk_in);
    endtask

    // Fresh timer values, one pin change, and the expected effect noted
    task automatic edge_to(input logic v);
        logic cap;
        logic [2:0] m;
        m = ctl[2:0];
        t1 <= 16'($random(seed));
        t2 <= 16'($random(seed));
        src.drive(v, 3);
        cap = (m == 3'h1) || (m == 3'h2 && !v) || (m == 3'h3 && v);
        if ((m == 3'h4 || m == 3'h5) && v) begin
            pre++;
            cap = (pre == ((m == 3'h4) ? 4 : 16));
            if (cap) pre = 0;
        end
        if (ctl[13] && idle) cap = 1'b0;
        if (m == 3'h7 && v && (idle || sleep)) st[2] = 1'b1;
        if (cap && caps.size() == `FIFO_DEPTH) begin
            ovf = 1'b1;
            st[1] = 1'b1;
        end else if (cap) begin
            caps.push_back(ctl[7] ? t1 : t2);
            cnt++;
            if (m == 3'h1 || cnt == ctl[6:5] + 1) begin
                st[0] = 1'b1;
                cnt = 0;
            end
        end
    endtask

    task automatic pulse();
        edge_to(1'b1);
        edge_to(1'b0);
    endtask

    // Empty the buffer oldest first, then once more on the empty buffer
    task automatic drain();
        while (caps.size() > 0) bus(1'b0, `ADDR_BUFFER, caps.pop_front());
        ovf = 1'b0;
        bus(1'b0, `ADDR_BUFFER, 16'h0000);
        rd_ctl();
    endtask

    initial begin
        {fails, n_checks, pre, cnt, wakes} = '0;
        seed = 92780;
        {wr, rd, rd_d, idle, sleep, ovf} = '0;
        {t1, t2, wdata, ctl, addr, st, mask} = '0;
        rst_in = 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        rd_ctl();
        rd_st();
        bus(1'b0, 4'hf, 16'h0000);
        bus(1'b1, `ADDR_IRQ_MASK, 16'hffff);
        mask = 3'h7;
        bus(1'b0, `ADDR_IRQ_MASK, 16'h0007);
        set_ctl(16'hffff);
        rd_ctl();
        // Every mode but the wake mode, on both timebases
        for (int i = 0; i < 14; i++) begin
            set_ctl({8'h00, i[0], 4'h0, i[3:1]});
            pulse();
            rd_st();
            clr_st(3'h7);
            drain();
        end
        // Prescaler restarts on a mode change
        set_ctl(16'h0004);
        repeat (2) pulse();
        set_ctl(16'h0004);
        repeat (8) pulse();
        drain();
        set_ctl(16'h0085);
        repeat (16) pulse();
        drain();
        clr_st(3'h7);
        // Captures per interrupt, checked before and at the count
        for (int c = 0; c < 4; c++) begin
            set_ctl({9'h0, c[1:0], 5'h03});
            for (int k = 0; k <= c; k++) begin
                pulse();
                rd_st();
            end
            clr_st(3'h7);
            drain();
        end
        set_ctl(16'h0061);
        edge_to(1'b1);
        rd_st();
        clr_st(3'h7);
        edge_to(1'b0);
        rd_st();
        bus(1'b1, `ADDR_IRQ_MASK, 16'h0000);
        mask = 3'h0;
        rd_st();
        bus(1'b1, `ADDR_IRQ_MASK, 16'h0007);
        mask = 3'h7;
        clr_st(3'h7);
        drain();
        // Fifth capture into a full buffer
        set_ctl(16'h0003);
        repeat (5) pulse();
        rd_ctl();
        rd_st();
        clr_st(3'h7);
        drain();
        // Idle halt on and off
        set_ctl(16'h2003);
        set_pwr(1'b1, 1'b0);
        pulse();
        set_pwr(1'b0, 1'b0);
        pulse();
        set_ctl(16'h0083);
        set_pwr(1'b1, 1'b0);
        pulse();
        set_pwr(1'b0, 1'b0);
        drain();
        clr_st(3'h7);
        // Wake source mode ignores the idle halt bit
        set_ctl(16'h2007);
        wakes = 0;
        pulse();
        set_pwr(1'b0, 1'b1);
        pulse();
        bus(1'b0, `ADDR_POWER, 16'h0001 << `PWR_SLEEP);
        rd_st();
        chk(16'(wakes), 16'h0001);
        set_pwr(1'b1, 1'b0);
        pulse();
        chk(16'(wakes), 16'h0002);
        set_pwr(1'b0, 1'b0);
        rd_ctl();
        repeat (3) @(posedge clk_in);
        print_verdict();
    end

    // Runs take about a thousand cycles; far beyond that is a hang
    initial begin
        repeat (40000) @(posedge clk_in);
        fails++;
        print_verdict();
    end
endmodule
`default_nettype wire
